// file: verilog/gplut_pkg.sv
/*
  package for the lookup-table output logic of the 16-channel expander:
  register offsets, reset values and the logic mode codes.
  assumes nothing of its surroundings; imported by every design file.
*/
`default_nettype none

package gplut_pkg;

  // register offsets on the internal register port (byte addresses)
  localparam logic [7:0] GPLUT_OFS_B_UPPER_IO15 = 8'h24;
  localparam logic [7:0] GPLUT_OFS_A_UPPER_IO7  = 8'h25;
  localparam logic [7:0] GPLUT_OFS_B_LOWER_IO11 = 8'h26;

  // values after reset
  localparam logic [7:0]  GPLUT_RST_TABLE = 8'h00;
  localparam logic [7:0]  GPLUT_RST_RDATA = 8'h00;
  localparam logic [15:0] GPLUT_RST_PINS  = 16'h0000;
  localparam logic [15:0] GPLUT_RST_OE_N  = 16'hffff;

  // pin positions of the three lookup outputs and their select groups
  localparam int GPLUT_POS_IO7  = 7;
  localparam int GPLUT_POS_IO11 = 11;
  localparam int GPLUT_POS_IO15 = 15;
  localparam int GPLUT_SEL_IO7  = 4;
  localparam int GPLUT_SEL_IO11 = 8;
  localparam int GPLUT_SEL_IO15 = 12;

  // logic mode of one nibble of a bank
  typedef enum logic [1:0] {
    GPLUT_MODE_OFF     = 2'h0,
    GPLUT_MODE_2TO1    = 2'h1,
    GPLUT_MODE_3TO1    = 2'h2,
    GPLUT_MODE_3TO2    = 2'h3
  } gplut_mode_t;

endpackage : gplut_pkg

`default_nettype wire

// file: verilog/gplut_cell.sv
/*
  one lookup cell: picks a table bit by a 3-bit pin code, or falls back
  to the ordinary data and direction of the pin when not enabled.
  assumes the caller registers the result; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none

module gplut_cell
  import gplut_pkg::*;
(
  input  wire logic [7:0] table_bits,
  input  wire logic [2:0] sel,
  input  wire logic       lut_enable,
  input  wire logic       plain_data,
  input  wire logic       plain_dir_input,
  output logic            out_val,
  output logic            out_oe_n
);

  // the table only counts while enabled; its contents stay untouched
  always_comb begin
    if (lut_enable) begin
      out_val  = table_bits[sel];   // code n picks bit n
      out_oe_n = 1'b0;              // a lookup output always drives
    end else begin
      out_val  = plain_data;
      out_oe_n = plain_dir_input;
    end
  end

endmodule : gplut_cell

`default_nettype wire

// file: verilog/gplut_top.sv
/*
  lookup-table output logic for pins 7, 11 and 15 of a 16-channel
  expander, with the three table registers and their register port.

  register map on the internal register port (byte offsets):
    0x24  bank b upper table, drives pin 15 from pins 14:12
    0x25  bank a upper table, drives pin 7 from pins 6:4
    0x26  bank b lower table, drives pin 11 from pins 10:8
  any other offset is ignored on write and reads back as zero here,
  so a slave that shares the port must merge its own read data.

  each table is an eight-entry truth table: the 3-bit code on the
  select pins picks one bit, code n picking bit n, and that bit is
  driven onto the output pin while the bank nibble is in 3-to-1 mode.
  in any other mode the pin behaves as an ordinary pin and the table
  keeps its contents, so a mode switch never needs a rewrite.
  limitation: the 3-to-2 mode is served by other tables outside this
  block, so here these pins fall back to ordinary drive in that mode.

  timing: a write lands on the edge that takes the strobe, a read
  answers on reg_rdata on that same edge and holds until the next read,
  and every pin output lags its inputs by exactly one edge.

  assumes a serial slave elsewhere turns bus traffic into the single-cycle
  reg_wr / reg_rd strobes here, that pin inputs are synchronous to clk,
  and that the mode codes come from mode registers kept elsewhere.
*/
`timescale 1ns/1ps
`default_nettype none

module gplut_top
  import gplut_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [1:0]  bank_a_upper_logic_mode,
  input  wire logic [1:0]  bank_b_lower_logic_mode,
  input  wire logic [1:0]  bank_b_upper_logic_mode,
  input  wire logic [15:0] io_in,
  input  wire logic [15:0] gpio_data,
  input  wire logic [15:0] gpio_dir_input,
  output logic      [15:0] io_out,
  output logic      [15:0] io_oe_n
);

  // table registers and their next values
  logic [7:0]  lut_bank_a_upper_io7;
  logic [7:0]  lut_bank_b_lower_io11;
  logic [7:0]  lut_bank_b_upper_io15;
  logic [7:0]  next_lut_bank_a_upper_io7;
  logic [7:0]  next_lut_bank_b_lower_io11;
  logic [7:0]  next_lut_bank_b_upper_io15;
  // decoded write strobes, one per table
  logic        wr_a_upper_io7;
  logic        wr_b_lower_io11;
  logic        wr_b_upper_io15;
  // read-back and pin driver next values
  logic [7:0]  next_reg_rdata;
  logic [15:0] next_io_out;
  logic [15:0] next_io_oe_n;
  // per-pin lookup enables and cell results
  logic        en_io7;
  logic        en_io11;
  logic        en_io15;
  logic        val_io7;
  logic        val_io11;
  logic        val_io15;
  logic        oe_n_io7;
  logic        oe_n_io11;
  logic        oe_n_io15;

  // true when a mode code selects the 3-to-1 lookup function; the 3-to-2
  // function is served by other tables, so it is not a hit for these three
  function automatic logic gplut_is_lookup(input logic [1:0] mode);
    return (mode == GPLUT_MODE_3TO1);
  endfunction : gplut_is_lookup

  // true when a strobe is up at the given register offset
  function automatic logic gplut_hit(input logic       strobe,
                                     input logic [7:0] addr,
                                     input logic [7:0] ofs);
    return strobe && (addr == ofs);
  endfunction : gplut_hit

  // write decode: offsets outside the three tables belong elsewhere
  assign wr_a_upper_io7  = gplut_hit(reg_wr, reg_addr, GPLUT_OFS_A_UPPER_IO7);
  assign wr_b_lower_io11 = gplut_hit(reg_wr, reg_addr, GPLUT_OFS_B_LOWER_IO11);
  assign wr_b_upper_io15 = gplut_hit(reg_wr, reg_addr, GPLUT_OFS_B_UPPER_IO15);

  // table next values: a write replaces the whole byte, otherwise hold
  always_comb begin
    next_lut_bank_a_upper_io7  = lut_bank_a_upper_io7;
    next_lut_bank_b_lower_io11 = lut_bank_b_lower_io11;
    next_lut_bank_b_upper_io15 = lut_bank_b_upper_io15;
    if (wr_a_upper_io7) begin
      next_lut_bank_a_upper_io7 = reg_wdata;
    end
    if (wr_b_lower_io11) begin
      next_lut_bank_b_lower_io11 = reg_wdata;
    end
    if (wr_b_upper_io15) begin
      next_lut_bank_b_upper_io15 = reg_wdata;
    end
  end

  // tables clear on reset only; a mode change never touches them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lut_bank_a_upper_io7  <= GPLUT_RST_TABLE;
      lut_bank_b_lower_io11 <= GPLUT_RST_TABLE;
      lut_bank_b_upper_io15 <= GPLUT_RST_TABLE;
    end else begin
      lut_bank_a_upper_io7  <= next_lut_bank_a_upper_io7;
      lut_bank_b_lower_io11 <= next_lut_bank_b_lower_io11;
      lut_bank_b_upper_io15 <= next_lut_bank_b_upper_io15;
    end
  end

  // read-back mux; a write and a read to one offset in the same cycle
  // return the old byte, since the table only changes on the edge
  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        GPLUT_OFS_A_UPPER_IO7:  next_reg_rdata = lut_bank_a_upper_io7;
        GPLUT_OFS_B_LOWER_IO11: next_reg_rdata = lut_bank_b_lower_io11;
        GPLUT_OFS_B_UPPER_IO15: next_reg_rdata = lut_bank_b_upper_io15;
        default:                next_reg_rdata = GPLUT_RST_RDATA;  // unmapped reads zero
      endcase
    end
  end

  // read data is registered and stands until the next read strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= GPLUT_RST_RDATA;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // mode gating; tables keep their contents whatever the mode
  assign en_io7  = gplut_is_lookup(bank_a_upper_logic_mode);
  assign en_io11 = gplut_is_lookup(bank_b_lower_logic_mode);
  assign en_io15 = gplut_is_lookup(bank_b_upper_logic_mode);

  // pin 7 cell: select code from pins 6:4, used only in bank a upper 3-to-1
  // the select code is the pad level, so a driven select pin reads back too
  gplut_cell u_cell_io7 (
    .table_bits      (lut_bank_a_upper_io7),
    .sel             (io_in[GPLUT_SEL_IO7 +: 3]),
    .lut_enable      (en_io7),
    .plain_data      (gpio_data[GPLUT_POS_IO7]),
    .plain_dir_input (gpio_dir_input[GPLUT_POS_IO7]),
    .out_val         (val_io7),
    .out_oe_n        (oe_n_io7)
  );

  // pin 11 cell: select code from pins 10:8, used only in bank b lower 3-to-1
  // code n picks bit n, so code 110 picks bit 6 and code 111 bit 7
  gplut_cell u_cell_io11 (
    .table_bits      (lut_bank_b_lower_io11),
    .sel             (io_in[GPLUT_SEL_IO11 +: 3]),
    .lut_enable      (en_io11),
    .plain_data      (gpio_data[GPLUT_POS_IO11]),
    .plain_dir_input (gpio_dir_input[GPLUT_POS_IO11]),
    .out_val         (val_io11),
    .out_oe_n        (oe_n_io11)
  );

  // pin 15 cell: select code from pins 14:12, used only in bank b upper 3-to-1
  // code 000 picks bit 0, the lowest entry of the table
  gplut_cell u_cell_io15 (
    .table_bits      (lut_bank_b_upper_io15),
    .sel             (io_in[GPLUT_SEL_IO15 +: 3]),
    .lut_enable      (en_io15),
    .plain_data      (gpio_data[GPLUT_POS_IO15]),
    .plain_dir_input (gpio_dir_input[GPLUT_POS_IO15]),
    .out_val         (val_io15),
    .out_oe_n        (oe_n_io15)
  );

  // pin drivers: ordinary pins pass through, lookup pins overlay
  // registering costs one cycle of latency but keeps outputs glitch free
  always_comb begin
    // every pin starts from its own data and direction
    next_io_out                 = gpio_data;
    next_io_oe_n                = gpio_dir_input;
    // pin 7 from the bank a upper cell
    next_io_out[GPLUT_POS_IO7]  = val_io7;
    next_io_oe_n[GPLUT_POS_IO7] = oe_n_io7;
    // pin 11 from the bank b lower cell
    next_io_out[GPLUT_POS_IO11]  = val_io11;
    next_io_oe_n[GPLUT_POS_IO11] = oe_n_io11;
    // pin 15 from the bank b upper cell
    next_io_out[GPLUT_POS_IO15]  = val_io15;
    next_io_oe_n[GPLUT_POS_IO15] = oe_n_io15;
  end

  // every output comes straight from a flop; reset releases every pin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      io_out  <= GPLUT_RST_PINS;
      io_oe_n <= GPLUT_RST_OE_N;   // all pins released during reset
    end else begin
      io_out  <= next_io_out;
      io_oe_n <= next_io_oe_n;
    end
  end

endmodule : gplut_top

`default_nettype wire

// file: test/gplut_chk.sv
/*
  checker for the lookup outputs on pins 7, 11 and 15.
  assumes it is bound to gplut_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module gplut_chk
  import gplut_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [1:0]  bank_a_upper_logic_mode,
  input wire logic [1:0]  bank_b_lower_logic_mode,
  input wire logic [1:0]  bank_b_upper_logic_mode,
  input wire logic [15:0] io_in,
  input wire logic [15:0] gpio_data,
  input wire logic [15:0] gpio_dir_input,
  input wire logic [15:0] io_out,
  input wire logic [15:0] io_oe_n
);
  logic [7:0] sh [4];
  // shadow tables, since the real ones are not visible at the ports
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) sh <= '{default: 8'h00};
    else if (reg_wr && reg_addr inside {8'h24, 8'h25, 8'h26}) sh[reg_addr[1:0]] <= reg_wdata;
  end
  wire logic p7  = sh[1][io_in[6:4]];
  wire logic p11 = sh[2][io_in[10:8]];
  wire logic p15 = sh[0][io_in[14:12]];
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_pin7_lookup: assert property (bank_a_upper_logic_mode == GPLUT_MODE_3TO1
    |=> io_out[7] == $past(p7) && !io_oe_n[7]) else $error("pin 7 lookup wrong");
  a_pin7_plain: assert property (bank_a_upper_logic_mode != GPLUT_MODE_3TO1
    |=> io_oe_n[7] == $past(gpio_dir_input[7]) && io_out[7] == $past(gpio_data[7]))
    else $error("pin 7 plain wrong");
  a_pin11_lookup: assert property (bank_b_lower_logic_mode == GPLUT_MODE_3TO1
    |=> io_out[11] == $past(p11) && !io_oe_n[11]) else $error("pin 11 lookup wrong");
  a_pin11_plain: assert property (bank_b_lower_logic_mode != GPLUT_MODE_3TO1
    && !gpio_dir_input[11]
    |=> !io_oe_n[11] && io_out[11] == $past(gpio_data[11])) else $error("pin 11 plain wrong");
  a_pin15_lookup: assert property (bank_b_upper_logic_mode == GPLUT_MODE_3TO1
    |=> io_out[15] == $past(p15) && !io_oe_n[15]) else $error("pin 15 lookup wrong");
  a_pin15_plain: assert property (bank_b_upper_logic_mode != GPLUT_MODE_3TO1
    && gpio_dir_input[15]
    |=> io_oe_n[15]) else $error("pin 15 plain wrong");
endmodule : gplut_chk
bind gplut_top gplut_chk u_chk (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .bank_a_upper_logic_mode(bank_a_upper_logic_mode),
  .bank_b_lower_logic_mode(bank_b_lower_logic_mode), .io_in(io_in), .gpio_data(gpio_data),
  .bank_b_upper_logic_mode(bank_b_upper_logic_mode), .gpio_dir_input(gpio_dir_input),
  .io_out(io_out), .io_oe_n(io_oe_n));
`default_nettype wire

// file: test/gplut_pins.sv
/*
  pin model: resolves each pin from the device drive or the outside level.
  assumes the outside only drives pins that the device releases.
*/
`timescale 1ns/1ps
`default_nettype none
module gplut_pins (
  input  wire logic [15:0] io_out,
  input  wire logic [15:0] io_oe_n,
  input  wire logic [15:0] ext_level,
  output logic      [15:0] io_in
);
  // a driven pin reads back what the device drives
  assign io_in = (io_out & ~io_oe_n) | (ext_level & io_oe_n);
endmodule : gplut_pins
`default_nettype wire

// file: test/gplut_top_bench.sv
/*
  self-checking bench for gplut_top with the pin model.
  assumes inputs change at the falling edge only.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module gplut_top_bench
  import gplut_pkg::*;
;
  localparam logic [7:0] TA = 8'h81, TL = 8'h42, TU = 8'h35;
  logic        clk, reset_n, reg_wr, reg_rd;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [1:0]  mode;
  logic [15:0] io_in, gpio_data, gpio_dir_input, io_out, io_oe_n, ext_level;
  int          err_count, samples_checked;
  logic [2:0]  lut_pins;
  // rows: mode [7:6], select code [5:3], expected pins 15, 11 and 7 in [2:0];
  // plain drive is 1: a 0 proves the lookup path, a 1 off 3-to-1 the fallback
  logic [7:0]  rows [11] = '{8'h85, 8'h8a, 8'h94, 8'h98, 8'ha4, 8'hac, 8'hb2, 8'hb9,
                             8'hc7, 8'h77, 8'h1f};
  assign lut_pins = {io_out[15], io_out[11], io_out[7]};
  gplut_top DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bank_a_upper_logic_mode(mode), .bank_b_lower_logic_mode(mode),
    .bank_b_upper_logic_mode(mode), .io_in(io_in), .gpio_data(gpio_data),
    .gpio_dir_input(gpio_dir_input), .io_out(io_out), .io_oe_n(io_oe_n));
  gplut_pins u_pins (.io_out(io_out), .io_oe_n(io_oe_n), .ext_level(ext_level), .io_in(io_in));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a; reg_wdata = d; reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a; reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
  endtask : rd
  task results;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // watchdog: the tests need well under 100 cycles, so 2000 means a hang
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    results;
  end
  initial begin
    err_count = 0; samples_checked = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0;
    reg_wdata = 0; mode = 0; gpio_data = 16'h8880; gpio_dir_input = 16'h777f;
    ext_level = 0; reset_n = 0;
    repeat (10) @(negedge clk);
    `CHK(io_oe_n, GPLUT_RST_OE_N)
    reset_n = 1'b1;
    rd(8'h25); `CHK(reg_rdata, 8'h00)
    `CHK(io_oe_n, 16'h777f)
    `CHK(io_out, 16'h8880)
    wr(8'h24, TU); wr(8'h25, TA); wr(8'h26, TL); wr(8'h30, 8'hff);
    foreach (rows[i]) begin
      mode = rows[i][7:6];
      ext_level = {4{1'b0, rows[i][5:3]}};
      @(negedge clk);
      `CHK(lut_pins, rows[i][2:0])
    end
    // released pins: plain direction wins, tables stay intact
    mode = 2'h0; gpio_dir_input = 16'hffff;
    @(negedge clk);
    `CHK(io_oe_n, 16'hffff)
    rd(8'h25); `CHK(reg_rdata, TA)
    rd(8'h24); `CHK(reg_rdata, TU)
    rd(8'h30); `CHK(reg_rdata, 8'h00)
    wr(8'h26, 8'h5c); rd(8'h26); `CHK(reg_rdata, 8'h5c)
    // mid-run reset: pins released at once, tables cleared
    reset_n = 1'b0;
    @(negedge clk);
    `CHK(io_oe_n, GPLUT_RST_OE_N)
    `CHK(io_out, GPLUT_RST_PINS)
    reset_n = 1'b1;
    rd(8'h26); `CHK(reg_rdata, 8'h00)
    results;
  end
endmodule : gplut_top_bench
`default_nettype wire
